// ---- verif/bstap_ctl.sv ----
// Board test controller model driving the test pins.
// Assumes the bench calls step once per test clock period.
module bstap_ctl (
   output logic tck_o,
   output logic tms_o,
   output logic tms_conn_o,
   output logic tdi_o,
   output logic tdi_conn_o,
   input  logic tdo_i,
   input  logic tdo_oe_i
);
   timeunit 1ns;
   timeprecision 100ps;
   logic tms_v = 1'b1;
   logic tdi_v = 1'b1;
   initial tck_o = 1'b0;
   initial tms_conn_o = 1'b1;
   initial tdi_conn_o = 1'b1;
   // A released pin shows the inverse of its last level, so only a pull-up reads high.
   assign tms_o = tms_conn_o ? tms_v : ~tms_v;
   assign tdi_o = tdi_conn_o ? tdi_v : ~tdi_v;
   task automatic step(input logic m, d, output logic q, oe);
      tms_v = m;
      tdi_v = d;
      #40 tck_o = 1'b1;
      #80 tck_o = 1'b0;
      #40 q = tdo_i;
      oe = tdo_oe_i;
   endtask
endmodule

// ---- verif/bstap_port_bench.sv ----
// Self-checking bench for the test access port.
// Assumes the controller model and checker are compiled first.
`include "bstap_consts.vh"
module bstap_port_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        ref_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        tck, tms, tms_cn, tdi, tdi_cn, tdo, tdo_oe, q, oe;
   logic [2:0]  instr;
   logic [3:0]  state;
   logic [31:0] dout;
   int          fails = 0, checks = 0, cyc = 0;
   always #2 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         summarize();
      end
   end
   bstap_ctl u_bstap_ctl (.tck_o(tck), .tms_o(tms), .tms_conn_o(tms_cn), .tdi_o(tdi),
      .tdi_conn_o(tdi_cn), .tdo_i(tdo), .tdo_oe_i(tdo_oe));
   bstap_port u_bstap_port (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms),
      .tms_conn_i(tms_cn), .tdi_i(tdi), .tdi_conn_i(tdi_cn), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
      .instr_o(instr), .state_o(state));
   task automatic summarize;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic st(input logic m, d);
      u_bstap_ctl.step(m, d, q, oe);
   endtask
   // Idle, one scan of n bits, back to idle; ir picks the instruction path.
   task automatic scan(input logic ir, input int n, input logic [31:0] din);
      logic [31:0] d;
      logic [2:0]  old;
      d = din;
      old = instr;
      dout = 32'h0000_0000;
      st(1'b1, 1'b0);
      if (ir)
         st(1'b1, 1'b0);
      st(1'b0, 1'b0);
      for (int k = 0; k <= n; k++) begin
         st(k == n, k > 0 && d[0]);
         if (k > 0)
            d = d >> 1;
         if (k < n)
            dout[k] = q;
         chk("tdo_oe", k < n, oe);
      end
      chk("instr held", old, instr);
      st(1'b1, 1'b0);
      st(1'b0, 1'b0);
      if (ir)
         chk("instr", din[2:0], instr);
   endtask
   task automatic t_reset;
      chk("state", `BSTAP_S_RESET, state);
      chk("instr", `BSTAP_INS_IDCODE, instr);
      chk("tdo_oe", 1'b0, tdo_oe);
      st(1'b0, 1'b0);
      chk("state", `BSTAP_S_IDLE, state);
      scan(1'b0, 32, 32'h0000_0000);
      chk("id", `BSTAP_ID_CODE, dout);
   endtask
   // Each code is loaded, then a four-bit scan shows which register sits in the path.
   task automatic t_codes;
      logic [2:0] c [5] = '{3'h1, 3'h0, 3'h2, 3'h4, 3'h7};
      foreach (c[i]) begin
         scan(1'b1, 3, {29'h0, c[i]});
         chk("ir capture", 32'h1, dout);
         scan(1'b0, 4, 32'h0000_000b);
         chk("dr path", c[i] == 3'h1 ? `BSTAP_ID_CODE & 32'hf : 32'h6, dout);
      end
   endtask
   task automatic t_five;
      st(1'b1, 1'b0);
      st(1'b0, 1'b0);
      st(1'b0, 1'b0);
      chk("state", `BSTAP_S_SHIFT_DR, state);
      repeat (5) st(1'b1, 1'b0);
      chk("state", `BSTAP_S_RESET, state);
      chk("instr", `BSTAP_INS_IDCODE, instr);
      st(1'b0, 1'b0);
      scan(1'b1, 3, 32'h0000_0007);
      u_bstap_ctl.tdi_conn_o = 1'b0;
      scan(1'b0, 4, 32'h0000_0000);
      chk("pulled tdi", 32'he, dout);
      u_bstap_ctl.tms_conn_o = 1'b0;
      repeat (5) st(1'b1, 1'b0);
      chk("pulled tms", `BSTAP_S_RESET, state);
   endtask
   initial begin
      repeat (8) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      rst_i = 1'b0;
      repeat (3) @(negedge ref_clk_i);
      t_reset();
      t_codes();
      t_five();
      summarize();
   end
endmodule

// ---- verif/bstap_port_props.sv ----
// Port checker for the test access port, bound to its top module.
// Assumes test clock phases last many reference clocks.
`include "bstap_consts.vh"
module bstap_props (
   input logic       ref_clk_i,
   input logic       rst_i,
   input logic       tck_i,
   input logic       tms_i,
   input logic       tms_conn_i,
   input logic       tdo_o,
   input logic       tdo_oe_o,
   input logic [2:0] instr_o,
   input logic [3:0] state_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] hi_cnt;
   logic       tck_q;
   logic       shf;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   assign shf = state_o == `BSTAP_S_SHIFT_DR || state_o == `BSTAP_S_SHIFT_IR;
   // A released mode-select pin counts as high.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tck_q  <= 1'b0;
         hi_cnt <= 3'h0;
      end else begin
         tck_q <= tck_i;
         if (tck_i && !tck_q)
            hi_cnt <= (tms_i || !tms_conn_i) ? hi_cnt + {2'h0, hi_cnt != 3'h5} : 3'h0;
      end
   end
   a_state_on_rise: assert property ($changed(state_o) |-> tck_i)
      else $error("state moved with test clock low");
   a_tdo_on_fall: assert property ($changed({tdo_o, tdo_oe_o}) |-> !tck_i)
      else $error("output moved with test clock high");
   a_five_high: assert property (hi_cnt == 3'h5 |-> ##[0:8] state_o == 4'h0)
      else $error("no reset after five high edges");
   a_oe_rise: assert property ($rose(tdo_oe_o) |-> shf)
      else $error("output enabled outside shift");
   a_oe_fall: assert property ($fell(tdo_oe_o) |-> !shf)
      else $error("output released inside shift");
   a_reset_instr: assert property (state_o == 4'h0 ##1 state_o == 4'h0 |-> instr_o == 3'h1)
      else $error("reset left wrong instruction");
   a_instr_update: assert property ($changed(instr_o) |->
      state_o == `BSTAP_S_RESET || $past(state_o) == `BSTAP_S_UPD_IR)
      else $error("instruction changed outside update");
   a_capture_ir: assert property ($rose(tdo_oe_o) && state_o == 4'hb |-> tdo_o)
      else $error("instruction capture bit wrong");
   c_update: cover property (state_o == `BSTAP_S_UPD_IR);
   c_bypass: cover property (state_o == `BSTAP_S_SHIFT_DR && instr_o == `BSTAP_INS_BYPASS);
   c_five: cover property (hi_cnt == 3'h5);
endmodule
bind bstap_port bstap_props u_bstap_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
   .tck_i(tck_i), .tms_i(tms_i), .tms_conn_i(tms_conn_i), .tdo_o(tdo_o),
   .tdo_oe_o(tdo_oe_o), .instr_o(instr_o), .state_o(state_o));

// ---- verilog/bstap_consts.vh ----
// Constants for the boundary-scan test access port.
// Assumes inclusion by bstap_port.v, the port bench and the port checker; bstap_edge.v does not include it.
`ifndef BSTAP_CONSTS_VH
`define BSTAP_CONSTS_VH

// TAP controller state codes.
`define BSTAP_S_RESET      4'h0
`define BSTAP_S_IDLE       4'h1
`define BSTAP_S_SEL_DR     4'h2
`define BSTAP_S_CAP_DR     4'h3
`define BSTAP_S_SHIFT_DR   4'h4
`define BSTAP_S_EXIT1_DR   4'h5
`define BSTAP_S_PAUSE_DR   4'h6
`define BSTAP_S_EXIT2_DR   4'h7
`define BSTAP_S_UPD_DR     4'h8
`define BSTAP_S_SEL_IR     4'h9
`define BSTAP_S_CAP_IR     4'ha
`define BSTAP_S_SHIFT_IR   4'hb
`define BSTAP_S_EXIT1_IR   4'hc
`define BSTAP_S_PAUSE_IR   4'hd
`define BSTAP_S_EXIT2_IR   4'he
`define BSTAP_S_UPD_IR     4'hf

// Instruction register layout and codes.
`define BSTAP_IR_W         3
`define BSTAP_IR_CAPTURE   3'h1
`define BSTAP_INS_EXTEST   3'h0
`define BSTAP_INS_IDCODE   3'h1
`define BSTAP_INS_SAMPLEZ  3'h2
`define BSTAP_INS_SAMPLE   3'h4
`define BSTAP_INS_BYPASS   3'h7

// Identification register; the code value is arbitrary.
`define BSTAP_ID_W         32
`define BSTAP_ID_CODE      32'h0a5a_5001

// Consecutive high mode-select edges that force reset.
`define BSTAP_RESET_EDGES  3'h5

`endif

// ---- verilog/bstap_edge.v ----
// Two-flop synchroniser with edge detection for one external input.
// Assumes the input is asynchronous to ref_clk_i.
module bstap_edge (
   input  wire ref_clk_i,
   input  wire rst_i,
   input  wire rst_val_i,
   input  wire pin_i,
   output reg  level_o,
   output wire rise_o,
   output wire fall_o
);
   reg meta;
   reg prev;

   // Only the second flop reads the first stage; the edge logic reads the second and third.
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta    <= 1'b0;
         level_o <= 1'b0;
         prev    <= 1'b0;
      end else begin
         meta    <= pin_i | rst_val_i;
         level_o <= meta;
         prev    <= level_o;
      end
   end

   assign rise_o = level_o & ~prev;
   assign fall_o = ~level_o & prev;
endmodule

// ---- verilog/bstap_port.v ----
// Boundary-scan test access port: state machine, instruction, ID and bypass registers.
// Assumes the test clock, mode select and serial input come from the board, unsynchronised.
`include "bstap_consts.vh"

module bstap_port (
   input  wire                   ref_clk_i,
   input  wire                   rst_i,
   input  wire                   tck_i,
   input  wire                   tms_i,
   input  wire                   tms_conn_i,
   input  wire                   tdi_i,
   input  wire                   tdi_conn_i,
   output reg                    tdo_o,
   output reg                    tdo_oe_o,
   output reg  [`BSTAP_IR_W-1:0] instr_o,
   output reg  [3:0]             state_o
);
   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   wire tck_rise;
   wire tck_fall;
   wire tms_s;
   wire tdi_s;

   // An unconnected mode-select or serial-input pin reads high, modelling the internal pull-up.
   bstap_edge u_tck (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .rst_val_i (1'b0),
      .pin_i     (tck_i),
      .level_o   (),
      .rise_o    (tck_rise),
      .fall_o    (tck_fall)
   );
   bstap_edge u_tms (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .rst_val_i (~tms_conn_i),
      .pin_i     (tms_i),
      .level_o   (tms_s),
      .rise_o    (),
      .fall_o    ()
   );
   bstap_edge u_tdi (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .rst_val_i (~tdi_conn_i),
      .pin_i     (tdi_i),
      .level_o   (tdi_s),
      .rise_o    (),
      .fall_o    ()
   );

   // ---------------------------------------------------------------
   // Controller state codes
   // ---------------------------------------------------------------
   // Codes follow the shared header, so the checker and bench agree.
   localparam [3:0] ST_RESET    = `BSTAP_S_RESET;
   localparam [3:0] ST_IDLE     = `BSTAP_S_IDLE;
   localparam [3:0] ST_SEL_DR   = `BSTAP_S_SEL_DR;
   localparam [3:0] ST_CAP_DR   = `BSTAP_S_CAP_DR;
   localparam [3:0] ST_SHIFT_DR = `BSTAP_S_SHIFT_DR;
   localparam [3:0] ST_EXIT1_DR = `BSTAP_S_EXIT1_DR;
   localparam [3:0] ST_PAUSE_DR = `BSTAP_S_PAUSE_DR;
   localparam [3:0] ST_EXIT2_DR = `BSTAP_S_EXIT2_DR;
   localparam [3:0] ST_UPD_DR   = `BSTAP_S_UPD_DR;
   localparam [3:0] ST_SEL_IR   = `BSTAP_S_SEL_IR;
   localparam [3:0] ST_CAP_IR   = `BSTAP_S_CAP_IR;
   localparam [3:0] ST_SHIFT_IR = `BSTAP_S_SHIFT_IR;
   localparam [3:0] ST_EXIT1_IR = `BSTAP_S_EXIT1_IR;
   localparam [3:0] ST_PAUSE_IR = `BSTAP_S_PAUSE_IR;
   localparam [3:0] ST_EXIT2_IR = `BSTAP_S_EXIT2_IR;
   localparam [3:0] ST_UPD_IR   = `BSTAP_S_UPD_IR;

   // ---------------------------------------------------------------
   // Decoding functions
   // ---------------------------------------------------------------
   // Next controller state for a given mode-select level.
   function [3:0] step;
      input [3:0] s;
      input       m;
      begin
         case (s)
            ST_RESET: begin
               step = m ? ST_RESET : ST_IDLE;
            end
            ST_IDLE: begin
               step = m ? ST_SEL_DR : ST_IDLE;
            end
            ST_SEL_DR: begin
               step = m ? ST_SEL_IR : ST_CAP_DR;
            end
            ST_CAP_DR: begin
               step = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            end
            ST_SHIFT_DR: begin
               step = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            end
            ST_EXIT1_DR: begin
               step = m ? ST_UPD_DR : ST_PAUSE_DR;
            end
            ST_PAUSE_DR: begin
               step = m ? ST_EXIT2_DR : ST_PAUSE_DR;
            end
            ST_EXIT2_DR: begin
               step = m ? ST_UPD_DR : ST_SHIFT_DR;
            end
            ST_UPD_DR: begin
               step = m ? ST_SEL_DR : ST_IDLE;
            end
            ST_SEL_IR: begin
               step = m ? ST_RESET : ST_CAP_IR;
            end
            ST_CAP_IR: begin
               step = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            end
            ST_SHIFT_IR: begin
               step = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            end
            ST_EXIT1_IR: begin
               step = m ? ST_UPD_IR : ST_PAUSE_IR;
            end
            ST_PAUSE_IR: begin
               step = m ? ST_EXIT2_IR : ST_PAUSE_IR;
            end
            ST_EXIT2_IR: begin
               step = m ? ST_UPD_IR : ST_SHIFT_IR;
            end
            ST_UPD_IR: begin
               step = m ? ST_SEL_DR : ST_IDLE;
            end
            default: begin
               step = ST_RESET;
            end
         endcase
      end
   endfunction

   // True in the two states that move bits between the serial pins.
   function is_shift;
      input [3:0] s;
      begin
         is_shift = (s == ST_SHIFT_DR) || (s == ST_SHIFT_IR);
      end
   endfunction

   // True when the identification register owns the data path.
   function id_sel;
      input [`BSTAP_IR_W-1:0] ins;
      begin
         id_sel = (ins == `BSTAP_INS_IDCODE);
      end
   endfunction

   // ---------------------------------------------------------------
   // Controller state machine
   // ---------------------------------------------------------------
   reg [3:0]             next_state;
   reg [`BSTAP_IR_W-1:0] ir_shift;
   reg [`BSTAP_ID_W-1:0] dr_id;
   reg                   dr_byp;
   reg                   next_tdo;
   reg                   next_tdo_oe;

   // The table above returns to reset after at most five high edges.
   always @* begin
      next_state = step(state_o, tms_s);
   end

   // Only the test clock edges move this logic, so a stopped clock
   // freezes the port; nothing here reaches the memory datapath.
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_o <= ST_RESET;
      end else if (tck_rise) begin
         state_o <= next_state;
      end
   end

   // ---------------------------------------------------------------
   // Instruction register
   // ---------------------------------------------------------------
   // The shift stage is kept apart from the active instruction, so a
   // half-shifted code never steers the data path.
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ir_shift <= `BSTAP_IR_CAPTURE;
      end else if (tck_rise) begin
         case (state_o)
            ST_CAP_IR: begin
               ir_shift <= `BSTAP_IR_CAPTURE;
            end
            ST_SHIFT_IR: begin
               ir_shift <= {tdi_s, ir_shift[`BSTAP_IR_W-1:1]};
            end
            default: begin
               ir_shift <= ir_shift;
            end
         endcase
      end
   end

   // Entering reset restores identification at once, not one edge later.
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         instr_o <= `BSTAP_INS_IDCODE;
      end else if (tck_rise) begin
         if (next_state == ST_RESET) begin
            instr_o <= `BSTAP_INS_IDCODE;
         end else if (state_o == ST_UPD_IR) begin
            instr_o <= ir_shift;
         end
      end
   end

   // ---------------------------------------------------------------
   // Identification register
   // ---------------------------------------------------------------
   // The register only moves while identification is active, so other
   // instructions leave its contents untouched.
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         dr_id <= {`BSTAP_ID_W{1'b0}};
      end else if (tck_rise && id_sel(instr_o)) begin
         case (state_o)
            ST_CAP_DR: begin
               dr_id <= `BSTAP_ID_CODE;
            end
            ST_SHIFT_DR: begin
               dr_id <= {tdi_s, dr_id[`BSTAP_ID_W-1:1]};
            end
            default: begin
               dr_id <= dr_id;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Bypass register
   // ---------------------------------------------------------------
   // Boundary-scan cells are not built here; every non-ID instruction
   // routes through the bypass stage so the chain length stays defined.
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         dr_byp <= 1'b0;
      end else if (tck_rise) begin
         if (state_o == ST_CAP_DR) begin
            dr_byp <= 1'b0;
         end else if ((state_o == ST_SHIFT_DR) && !id_sel(instr_o)) begin
            dr_byp <= tdi_s;
         end
      end
   end

   // ---------------------------------------------------------------
   // Serial output, updated on the falling test clock edge
   // ---------------------------------------------------------------
   // The bit shown is the one present at the fall, so the far side
   // can sample it safely at the following rise.
   always @* begin
      next_tdo_oe = is_shift(state_o);
      if (state_o == ST_SHIFT_IR) begin
         next_tdo = ir_shift[0];
      end else if (id_sel(instr_o)) begin
         next_tdo = dr_id[0];
      end else begin
         next_tdo = dr_byp;
      end
   end

   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tdo_o    <= 1'b0;
         tdo_oe_o <= 1'b0;
      end else if (tck_fall) begin
         tdo_oe_o <= next_tdo_oe;
         tdo_o    <= next_tdo;
      end
   end
   // The port has no path into memory operation.
endmodule
